// ---- verilog/itx_pkg.sv ----
package itx_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
    localparam logic [7:0] IDX_INT_FLAG = 8'h0c;
    localparam logic [7:0] IDX_DATA_BUF = 8'h13;
    localparam logic [7:0] IDX_CONTROL  = 8'h14;
    localparam logic [7:0] IDX_DIRECT   = 8'h87;
    localparam logic [7:0] IDX_INT_EN   = 8'h8c;
    localparam logic [7:0] IDX_SLV_ADDR = 8'h93;
    localparam logic [7:0] IDX_STATUS   = 8'h94;

    // reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [5:0] RST_DIRECT = 6'h3f;

    // field positions
    localparam int CTRL_WRITE_COLLISION_FLAG = 7;
    localparam int CTRL_OV   = 6;
    localparam int CTRL_EN   = 5;
    localparam int CTRL_CKP  = 4;
    localparam int STAT_DA   = 5;
    localparam int STAT_STOP = 4;
    localparam int STAT_STRT = 3;
    localparam int STAT_RW   = 2;
    localparam int STAT_BF   = 0;
    localparam int FLAG_EVT  = 3;
    localparam int INTC_GIE  = 7;
    localparam int INTC_PERIPHERAL_INT_ENABLE = 6;
    localparam int DIR_SCL   = 3;
    localparam int DIR_SDA   = 4;

    // port mode select codes
    localparam logic [3:0] MODE_SLV7    = 4'h6;
    localparam logic [3:0] MODE_SLV10   = 4'h7;
    localparam logic [3:0] MODE_SLV7_SP = 4'he;
    localparam logic [3:0] MODE_SLV10_SP = 4'hf;
    localparam logic [3:0] MODE_FW_MAST = 4'hb;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_RXDATA, ST_ACK, ST_NACK, ST_HOLD, ST_TXDATA, ST_TXACK
    } itx_state_t;

endpackage

// ---- verilog/itx_line_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// synchronised bus lines and the conditions found on them
interface itx_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface
`default_nettype wire

// ---- verilog/itx_line_mon.sv ----
`timescale 1ns/1ps
`default_nettype none
module itx_line_mon
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    itx_line_if.src   lines
);

    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic       scl_q_r;
    logic       sda_q_r;

    ////////////////////////////////////////////////////////////////
    // two-stage synchronisers; idle bus reads high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], scl_pin};
            sda_sync_r <= {sda_sync_r[0], sda_pin};
        end
    end

    // previous settled sample for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_sync_r[1];
            sda_q_r <= sda_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////
    // conditions only from settled samples, never from the first stage
    assign lines.scl       = scl_sync_r[1];
    assign lines.sda       = sda_sync_r[1];
    assign lines.scl_rise  = scl_sync_r[1] & ~scl_q_r;
    assign lines.scl_fall  = ~scl_sync_r[1] & scl_q_r;
    assign lines.start_det = scl_sync_r[1] & scl_q_r & sda_q_r & ~sda_sync_r[1];
    assign lines.stop_det  = scl_sync_r[1] & scl_q_r & ~sda_q_r & sda_sync_r[1];

endmodule
`default_nettype wire

// ---- verilog/itx_i2c_port.sv ----
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module itx_i2c_port
    import itx_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic [9:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [3:0]  BYTEENABLE,
    output var  logic [31:0] READDATA,
    output logic             WAITREQUEST,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    output logic             IRQ
);

    itx_line_if lines ();

    logic       done_r;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wd;
    logic [7:0] intc_r;
    logic [7:0] pir_r;
    logic [7:0] pie_r;
    logic [5:0] dir_r;
    logic [7:0] saddr_r;
    logic [7:0] buf_r;
    logic       write_collision_flag_r;
    logic       ov_r;
    logic       en_r;
    logic       ckp_r;
    logic [3:0] mode_r;
    logic       da_r;
    logic       stop_r;
    logic       start_r;
    logic       rw_r;
    logic       bf_r;
    logic [7:0] shift_r;
    logic [3:0] cnt_r;
    logic       sda_drv_r;
    logic       ack_ok_r;
    itx_state_t state_r;
    logic       slave_on;
    logic       i2c_on;
    logic       sp_events;
    logic       byte8_fall;
    logic       addr_match;
    logic       busy_full;
    logic       take_addr;
    logic       take_data;
    logic       overflow;
    logic       ninth_fall;
    logic       hold_enter;
    logic       tx_busy;
    logic       ev_set;
    logic       scl_hold;

    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    itx_line_mon u_mon
    (
        .clk     (CLOCK),
        .rst     (RESET),
        .scl_pin (SCL_I),
        .sda_pin (SDA_I),
        .lines   (lines)
    );

    ////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, access acts when waitrequest is low
    assign WAITREQUEST = (READ | WRITE) & ~done_r;
    assign wr_go       = WRITE & done_r & BYTEENABLE[0];
    assign rd_go       = READ & done_r;
    assign wd          = WRITEDATA[7:0];

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            done_r <= 1'b0;
        else
            done_r <= (READ | WRITE) & ~done_r;
    end

    // read data captured in the wait cycle so it stands at the answer edge
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            READDATA <= 32'h0;
        else if (READ & ~done_r)
        begin
            READDATA <= 32'h0;
            if (hit(ADDRESS, IDX_INT_CTRL))
                READDATA[7:0] <= intc_r;
            else if (hit(ADDRESS, IDX_INT_FLAG))
                READDATA[7:0] <= pir_r;
            else if (hit(ADDRESS, IDX_INT_EN))
                READDATA[7:0] <= pie_r;
            else if (hit(ADDRESS, IDX_DIRECT))
                READDATA[7:0] <= {2'h0, dir_r};
            else if (hit(ADDRESS, IDX_SLV_ADDR))
                READDATA[7:0] <= saddr_r;
            else if (hit(ADDRESS, IDX_DATA_BUF))
                READDATA[7:0] <= buf_r;
            else if (hit(ADDRESS, IDX_CONTROL))
                READDATA[7:0] <= {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r};
            else if (hit(ADDRESS, IDX_STATUS))
                READDATA[7:0] <= {2'h0, da_r, stop_r, start_r, rw_r, 1'b0, bf_r};
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode decode; everything is gated by the port enable bit
    assign slave_on  = en_r & ((mode_r == MODE_SLV7) | (mode_r == MODE_SLV10) |
                               (mode_r == MODE_SLV7_SP) | (mode_r == MODE_SLV10_SP));
    assign i2c_on    = slave_on | (en_r & (mode_r == MODE_FW_MAST));
    assign sp_events = en_r & ((mode_r == MODE_SLV7_SP) | (mode_r == MODE_SLV10_SP) |
                               (mode_r == MODE_FW_MAST));

    // byte-level decisions taken from the slave state
    assign byte8_fall = lines.scl_fall & (cnt_r == BITS_PER_BYTE);
    assign addr_match = shift_r[7:1] == saddr_r[7:1];
    assign busy_full  = bf_r | ov_r;
    assign take_addr  = (state_r == ST_ADDR) & byte8_fall & addr_match & ~busy_full;
    assign take_data  = (state_r == ST_RXDATA) & byte8_fall & ~busy_full;
    assign overflow   = byte8_fall & busy_full &
                        (((state_r == ST_ADDR) & addr_match) | (state_r == ST_RXDATA));
    assign ninth_fall = lines.scl_fall &
                        ((state_r == ST_ACK) | (state_r == ST_NACK) | (state_r == ST_TXACK));
    assign hold_enter = lines.scl_fall & (((state_r == ST_ACK) & rw_r) |
                                          ((state_r == ST_TXACK) & ack_ok_r));
    assign tx_busy    = (state_r == ST_TXDATA) | (state_r == ST_TXACK);
    assign ev_set     = ninth_fall | (sp_events & (lines.start_det | lines.stop_det));

    ////////////////////////////////////////////////////////////////
    // slave sequencer: runs on synchronised clock edges
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            state_r   <= ST_IDLE;
            cnt_r     <= 4'h0;
            sda_drv_r <= 1'b0;
            ack_ok_r  <= 1'b0;
        end
        else if (!slave_on)
        begin
            state_r   <= ST_IDLE;
            sda_drv_r <= 1'b0;
        end
        else if (lines.stop_det)
        begin
            state_r   <= ST_IDLE;
            sda_drv_r <= 1'b0;
        end
        else if (lines.start_det)
        begin
            // listening goes on even if our own master lost the bus
            state_r   <= ST_ADDR;
            cnt_r     <= 4'h0;
            sda_drv_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE: ;
                ST_ADDR, ST_RXDATA:
                begin
                    if (lines.scl_rise)
                        cnt_r <= cnt_r + 4'h1;
                    else if (byte8_fall)
                    begin
                        cnt_r <= 4'h0;
                        if (take_addr | take_data)
                        begin
                            sda_drv_r <= 1'b1;
                            state_r   <= ST_ACK;
                        end
                        else if (overflow)
                            state_r <= ST_NACK;
                        else
                            state_r <= ST_IDLE;
                    end
                end
                ST_ACK, ST_NACK:
                begin
                    if (lines.scl_fall)
                    begin
                        sda_drv_r <= 1'b0;
                        cnt_r     <= 4'h0;
                        state_r   <= (state_r == ST_ACK && rw_r) ? ST_HOLD : ST_RXDATA;
                    end
                end
                ST_HOLD:
                begin
                    // clock stays low until software sets the release bit
                    if (ckp_r)
                    begin
                        sda_drv_r <= ~shift_r[7];
                        cnt_r     <= 4'h0;
                        state_r   <= ST_TXDATA;
                    end
                end
                ST_TXDATA:
                begin
                    if (lines.scl_fall)
                    begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == BITS_PER_BYTE - 4'h1)
                        begin
                            sda_drv_r <= 1'b0;
                            state_r   <= ST_TXACK;
                        end
                        else
                            sda_drv_r <= ~shift_r[6];
                    end
                end
                ST_TXACK:
                begin
                    if (lines.scl_rise)
                        ack_ok_r <= ~lines.sda;
                    else if (lines.scl_fall)
                        state_r <= ack_ok_r ? ST_HOLD : ST_IDLE;
                end
            endcase
        end
    end

    // shift register: receive on rising edges, send on falling edges
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            shift_r <= RST_ZERO;
        else if (wr_go && hit(ADDRESS, IDX_DATA_BUF) && !tx_busy)
            shift_r <= wd;
        else if (lines.scl_rise && (state_r == ST_ADDR || state_r == ST_RXDATA))
            shift_r <= {shift_r[6:0], lines.sda};
        else if (lines.scl_fall && state_r == ST_TXDATA)
            shift_r <= {shift_r[6:0], 1'b0};
    end

    ////////////////////////////////////////////////////////////////
    // plain software registers
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            intc_r  <= RST_ZERO;
            pie_r   <= RST_ZERO;
            dir_r   <= RST_DIRECT;
            saddr_r <= RST_ZERO;
        end
        else if (wr_go)
        begin
            if (hit(ADDRESS, IDX_INT_CTRL))
                intc_r <= wd;
            if (hit(ADDRESS, IDX_INT_EN))
                pie_r <= wd;
            if (hit(ADDRESS, IDX_DIRECT))
                dir_r <= wd[5:0];
            if (hit(ADDRESS, IDX_SLV_ADDR))
                saddr_r <= wd;
        end
    end

    // interrupt flags: a hardware set beats a software clear
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            pir_r <= RST_ZERO;
        else
        begin
            if (wr_go && hit(ADDRESS, IDX_INT_FLAG))
                pir_r <= wd;
            if (ev_set)
                pir_r[FLAG_EVT] <= 1'b1;
        end
    end

    // control register; overflow and collision are cleared only by writes
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            write_collision_flag_r <= 1'b0;
            ov_r   <= 1'b0;
            en_r   <= 1'b0;
            ckp_r  <= 1'b0;
            mode_r <= 4'h0;
        end
        else
        begin
            if (hold_enter)
                ckp_r <= 1'b0;
            if (wr_go && hit(ADDRESS, IDX_CONTROL))
            begin
                write_collision_flag_r <= wd[CTRL_WRITE_COLLISION_FLAG];
                ov_r   <= wd[CTRL_OV];
                en_r   <= wd[CTRL_EN];
                ckp_r  <= wd[CTRL_CKP];
                mode_r <= wd[3:0];
            end
            if (overflow)
                ov_r <= 1'b1;
            if (wr_go && hit(ADDRESS, IDX_DATA_BUF) && tx_busy)
                write_collision_flag_r <= 1'b1;
        end
    end

    // data buffer and byte status
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            buf_r <= RST_ZERO;
            bf_r  <= 1'b0;
            rw_r  <= 1'b0;
            da_r  <= 1'b0;
        end
        else
        begin
            if (rd_go && hit(ADDRESS, IDX_DATA_BUF))
                bf_r <= 1'b0;
            if (wr_go && hit(ADDRESS, IDX_DATA_BUF))
                buf_r <= wd;
            if (take_addr)
            begin
                buf_r <= shift_r;
                bf_r  <= 1'b1;
                rw_r  <= shift_r[0];
                da_r  <= 1'b0;
            end
            else if (take_data)
            begin
                buf_r <= shift_r;
                bf_r  <= 1'b1;
                da_r  <= 1'b1;
            end
            else if (lines.scl_fall && state_r == ST_TXACK)
                da_r <= 1'b1;
        end
    end

    // start and stop seen flags, cleared while the port is off
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end
        else if (!en_r)
        begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end
        else if (lines.start_det)
        begin
            start_r <= 1'b1;
            stop_r  <= 1'b0;
        end
        else if (lines.stop_det)
        begin
            start_r <= 1'b0;
            stop_r  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // open-drain pins: level is always low, enables decide.
    // output direction pulls low in an enabled I2C mode whatever the port latch holds
    assign scl_hold = state_r == ST_HOLD;
    assign SCL_O    = 1'b0;
    assign SDA_O    = 1'b0;
    assign SCL_OE   = (i2c_on & ~dir_r[DIR_SCL]) | scl_hold;
    assign SDA_OE   = (i2c_on & ~dir_r[DIR_SDA]) | sda_drv_r;

    // interrupt request needs the event flag and all three enables
    assign IRQ = pir_r[FLAG_EVT] & pie_r[FLAG_EVT] & intc_r[INTC_PERIPHERAL_INT_ENABLE] & intc_r[INTC_GIE];

endmodule
`default_nettype wire

// ---- testbench/itx_i2c_port_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module itx_i2c_port_monitor
(
    input wire logic        CLOCK,
    input wire logic        RESET,
    input wire logic [9:0]  ADDRESS,
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0]  BYTEENABLE,
    input wire logic [31:0] READDATA,
    input wire logic        WAITREQUEST,
    input wire logic        SCL_I,
    input wire logic        SCL_O,
    input wire logic        SCL_OE,
    input wire logic        SDA_I,
    input wire logic        SDA_O,
    input wire logic        SDA_OE,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////
    // pin inputs pass two sync flops, so look two clocks back
    sequence s_one_wait;
        WAITREQUEST ##1 !WAITREQUEST;
    endsequence
    sequence s_bit_held;
        SDA_OE [*3];
    endsequence
    AST_ONE_WAIT:
    assert property ($rose(READ || WRITE) |-> s_one_wait) else $error("bus wait not single");
    AST_RDATA_HI:
    assert property (READDATA[31:8] == 24'h0) else $error("read data upper lane set");
    AST_OD_LOW:
    assert property (!SCL_O && !SDA_O) else $error("pin driven high");
    AST_SDA_LOW_PH:
    assert property ($changed(SDA_OE) |-> !$past(SCL_I, 2) || $past(WRITE) || $past(WRITE, 2))
        else $error("data moved in clock high");
    AST_SDA_HELD:
    assert property ($rose(SDA_OE) && !$past(WRITE) |-> s_bit_held) else $error("data bit too short");
    AST_SCL_GRAB:
    assert property ($rose(SCL_OE) |-> !$past(SCL_I, 2) || $past(WRITE) || $past(WRITE, 2))
        else $error("clock grabbed while high");
    AST_SCL_FREE:
    assert property ($fell(SCL_OE) |-> $past(WRITE) || $past(WRITE, 2)) else $error("clock freed unasked");
    AST_IRQ_CLR:
    assert property ($fell(IRQ) |-> $past(WRITE) || $past(WRITE, 2)) else $error("irq dropped unasked");
endmodule
bind itx_i2c_port itx_i2c_port_monitor i_mon (.CLOCK, .RESET, .ADDRESS, .READ, .WRITE, .WRITEDATA,
    .BYTEENABLE, .READDATA, .WAITREQUEST, .SCL_I, .SCL_O, .SCL_OE, .SDA_I, .SDA_O, .SDA_OE, .IRQ);
`default_nettype wire

// ---- testbench/itx_mst_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module itx_mst_model
(
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    // released at time zero, the pull-ups lift both lines
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // only called on an idle bus, after stop or reset
    task automatic start();
        @(posedge clk);
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b1;
        half();
    endtask
    task automatic stop();
        @(posedge clk);
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b0;
        half();
        sda_oe <= 1'b0;
        half();
    endtask
    // nine bits msb first, four clocks low and four high
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        int n;
        for (int i = 8; i >= 0; i--)
        begin
            repeat (2) @(posedge clk);
            sda_oe <= !d[i];
            repeat (2) @(posedge clk);
            scl_oe <= 1'b0;
            n = 0;
            // a stretching slave keeps the low phase going
            do @(posedge clk); while (!scl && n++ < 4000);
            repeat (3) @(posedge clk);
            q[i] = sda;
            scl_oe <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/itx_i2c_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module itx_i2c_port_tb_top
    import itx_pkg::*;
;
    logic        CLOCK, RESET, READ, WRITE, WAITREQUEST;
    logic        SCL_O, SCL_OE, SDA_O, SDA_OE, IRQ, m_scl_oe, m_sda_oe;
    logic [9:0]  ADDRESS;
    logic [31:0] WRITEDATA, READDATA;
    logic [3:0]  BYTEENABLE;
    logic [7:0]  q;
    logic [8:0]  b;
    int          error_cnt, n_checks;
    wire         scl_w = !(SCL_OE || m_scl_oe);
    wire         sda_w = !(SDA_OE || m_sda_oe);
    localparam logic [15:0] RV [8] = '{16'h0b00, 16'h0c00, 16'h1400, 16'h873f,
                                        16'h8c00, 16'h9300, 16'h9400, 16'h2000};
    localparam logic [7:0]  TX [2] = '{8'ha5, 8'h3c};
    ////////////////////////////////////////////////////////////
    itx_i2c_port i_dut (.CLOCK, .RESET, .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
        .WAITREQUEST, .SCL_I(scl_w), .SCL_O, .SCL_OE, .SDA_I(sda_w), .SDA_O, .SDA_OE, .IRQ);
    itx_mst_model i_mst (.clk(CLOCK), .scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
    // 40 MHz core clock
    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = !CLOCK;
    end
    ////////////////////////////////////////////////////////////
    // one bus cycle; held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
        @(posedge CLOCK);
        ADDRESS   <= {idx, 2'b00};
        WRITEDATA <= {24'h0, d};
        READ      <= !w;
        WRITE     <= w;
        // waitrequest and read data are taken at the rising edge itself; only the watchdog ends a hang
        do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
        r = READDATA[7:0];
        READ  <= 1'b0;
        WRITE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d, q);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        acc(1'b0, idx, 8'h00, q);
        chk($sformatf("reg %h", idx), e, q & m);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // a hung handshake or link ends the run as a failure
    initial
    begin
        repeat (40000) @(posedge CLOCK);
        error_cnt++;
        stop_test();
    end
    // main sequence
    initial
    begin
        RESET = 1'b1;
        READ = 1'b0;
        WRITE = 1'b0;
        ADDRESS = 10'h0;
        WRITEDATA = 32'h0;
        BYTEENABLE = 4'h1;
        error_cnt = 0;
        n_checks = 0;
        repeat (16) @(posedge CLOCK);
        RESET <= 1'b0;
        // reset values, last entry unmapped
        for (int i = 0; i < 8; i++)
            rdc(RV[i][15:8], 8'hff, RV[i][7:0]);
        wr(IDX_STATUS, 8'hff);
        rdc(IDX_STATUS, 8'hff, 8'h00);
        wr(IDX_SLV_ADDR, 8'hb4);
        // a write without the low byte lane is ignored
        BYTEENABLE <= 4'h0;
        wr(IDX_SLV_ADDR, 8'h00);
        BYTEENABLE <= 4'h1;
        rdc(IDX_SLV_ADDR, 8'hff, 8'hb4);
        wr(IDX_INT_EN, 8'h08);
        wr(IDX_INT_CTRL, 8'hc0);
        wr(IDX_CONTROL, 8'h36);
        i_mst.start();
        rdc(IDX_STATUS, 8'h18, 8'h08);
        i_mst.xfer({8'hb5, 1'b1}, b);
        chk("addr ack", 8'h00, b[0]);
        repeat (6) @(negedge CLOCK);
        chk("scl hold", 8'h01, SCL_OE);
        chk("irq", 8'h01, IRQ);
        rdc(IDX_STATUS, 8'h05, 8'h05);
        rdc(IDX_DATA_BUF, 8'hff, 8'hb5);
        rdc(IDX_STATUS, 8'h01, 8'h00);
        // acked byte keeps the hold, refused byte frees the slave
        for (int i = 0; i < 2; i++)
        begin
            rdc(IDX_INT_FLAG, 8'h08, 8'h08);
            wr(IDX_INT_FLAG, 8'h00);
            @(negedge CLOCK);
            chk("irq clr", 8'h00, IRQ);
            wr(IDX_DATA_BUF, TX[i]);
            wr(IDX_CONTROL, 8'h36);
            repeat (3) @(negedge CLOCK);
            chk("scl free", 8'h00, SCL_OE);
            i_mst.xfer({8'hff, i[0]}, b);
            chk("tx byte", TX[i], b[8:1]);
            repeat (6) @(negedge CLOCK);
            chk("scl after ack", !i[0], SCL_OE);
        end
        i_mst.stop();
        rdc(IDX_STATUS, 8'h18, 8'h10);
        // second byte lands while the buffer is still full; this mode also flags start
        wr(IDX_CONTROL, 8'h3e);
        wr(IDX_INT_FLAG, 8'h00);
        i_mst.start();
        rdc(IDX_INT_FLAG, 8'h08, 8'h08);
        i_mst.xfer({8'hb4, 1'b1}, b);
        chk("wr addr ack", 8'h00, b[0]);
        i_mst.xfer({8'h11, 1'b1}, b);
        chk("full nack", 8'h01, b[0]);
        rdc(IDX_CONTROL, 8'h40, 8'h40);
        rdc(IDX_DATA_BUF, 8'hff, 8'hb4);
        rdc(IDX_CONTROL, 8'h40, 8'h40);
        i_mst.stop();
        wr(IDX_CONTROL, 8'h06);
        rdc(IDX_STATUS, 8'h18, 8'h00);
        // firmware master mode through the direction bits
        wr(IDX_CONTROL, 8'h2b);
        wr(IDX_DIRECT, 8'h2f);
        @(negedge CLOCK);
        chk("sda drive", 8'h01, SDA_OE);
        wr(IDX_DIRECT, 8'h3f);
        @(negedge CLOCK);
        chk("sda free", 8'h00, SDA_OE);
        // let the stop made by the released line land before clearing
        repeat (4) @(posedge CLOCK);
        wr(IDX_INT_FLAG, 8'h00);
        rdc(IDX_INT_FLAG, 8'h08, 8'h00);
        i_mst.start();
        rdc(IDX_INT_FLAG, 8'h08, 8'h08);
        // another master holds data low: release both lines and stand back
        if (sda_w === 1'b0)
            wr(IDX_DIRECT, 8'h3f);
        @(negedge CLOCK);
        chk("arb release", 8'h00, {6'h0, SCL_OE, SDA_OE});
        wr(IDX_INT_FLAG, 8'h00);
        i_mst.stop();
        @(negedge CLOCK);
        chk("stop irq", 8'h01, IRQ);
        rdc(IDX_STATUS, 8'h18, 8'h10);
        // bus free again, so firmware drives a new start through the data direction bit
        wr(IDX_DIRECT, 8'h2f);
        repeat (4) @(posedge CLOCK);
        rdc(IDX_STATUS, 8'h18, 8'h08);
        stop_test();
    end
endmodule
`default_nettype wire
